// File: pbm_port_bus_mux.sv
`timescale 1ns/10ps
`default_nettype none

module pbm_port_bus_mux (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor side, sampled on cycle_start
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_rw,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_ext,
    output logic             cycle_start,
    output logic [7:0]       cpu_rdata,
    output logic             cpu_rdata_valid,
    output logic             phi2,
    // Pins
    input  wire logic        latch_strobe_pin,
    input  wire logic [7:0]  second_port_in,
    output logic      [7:0]  second_port_out,
    output logic      [7:0]  second_port_oe_n,
    input  wire logic [7:0]  third_port_in,
    output logic      [7:0]  third_port_out,
    output logic      [7:0]  third_port_oe_n,
    input  wire logic [7:0]  fourth_port_in,
    output logic      [7:0]  fourth_port_out,
    output logic      [7:0]  fourth_port_oe_n
);

    // ----------------------------------------------------------------
    // Synchronised pin inputs
    // ----------------------------------------------------------------
    logic [7:0] p2_sync;
    logic [7:0] p3_sync;
    logic [7:0] p4_sync;
    logic       strobe_sync;
    logic       strobe_prev;

    // Pins are asynchronous; nothing reads them before two stages
    pbm_sync #(.W(8)) u_sync_p2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (second_port_in),
        .sync_out (p2_sync)
    );
    pbm_sync #(.W(8)) u_sync_p3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (third_port_in),
        .sync_out (p3_sync)
    );
    pbm_sync #(.W(8)) u_sync_p4 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (fourth_port_in),
        .sync_out (p4_sync)
    );
    pbm_sync #(.W(1)) u_sync_stb (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (latch_strobe_pin),
        .sync_out (strobe_sync)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Mode holds bits 7:4 as written; bus mode and tri-state select reach the pins at a cycle edge, latch select at once
    logic [3:0]  mode_reg;
    logic [7:0]  p2_out;
    logic [7:0]  p2_dir;
    logic [7:0]  p3_out;
    logic [7:0]  p3_dir;
    logic [7:0]  p4_out;
    logic [7:0]  p4_dir;
    logic [7:0]  p2_latch;
    logic        latch_full;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire setup_rd  = psel && !penable && !pwrite;
    wire access_wr = psel && penable && pwrite;
    // Whole byte address compared, so aliases raise an error
    wire hit_mode  = (paddr == pbm_pkg::MODE_OFS);
    wire hit_p2o   = (paddr == pbm_pkg::P2_OUT_OFS);
    wire hit_p2d   = (paddr == pbm_pkg::P2_DIR_OFS);
    wire hit_p2i   = (paddr == pbm_pkg::P2_IN_OFS);
    wire hit_p3o   = (paddr == pbm_pkg::P3_OUT_OFS);
    wire hit_p3d   = (paddr == pbm_pkg::P3_DIR_OFS);
    wire hit_p3i   = (paddr == pbm_pkg::P3_IN_OFS);
    wire hit_p4o   = (paddr == pbm_pkg::P4_OUT_OFS);
    wire hit_p4d   = (paddr == pbm_pkg::P4_DIR_OFS);
    wire hit_p4i   = (paddr == pbm_pkg::P4_IN_OFS);
    wire hit_st    = (paddr == pbm_pkg::STATUS_OFS);
    wire mapped    = hit_mode | hit_p2o | hit_p2d | hit_p2i | hit_p3o |
                     hit_p3d | hit_p3i | hit_p4o | hit_p4d | hit_p4i |
                     hit_st;

    // Zero wait states; unmapped addresses raise an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Latched value replaces the pin level while latching is on
    wire latch_on      = mode_reg[pbm_pkg::LATCH_SEL_BIT - 4];
    wire [7:0] p2_read = latch_on ? p2_latch : p2_sync;

    // ----------------------------------------------------------------
    // Processor cycle timing
    // ----------------------------------------------------------------
    logic [3:0]  cyc_cnt;
    logic        phi2_q;
    logic [1:0]  act_mode;
    logic        act_tri;
    logic [15:0] acc_addr;
    logic        acc_rw;
    logic [7:0]  acc_wdata;
    logic        acc_ext;

    wire        cyc_end    = (cyc_cnt == pbm_pkg::CYC_LAST);
    wire [3:0]  next_cnt   = cyc_end ? 4'h0 : cyc_cnt + 4'h1;
    wire        next_phi2  = (next_cnt >= pbm_pkg::PHI2_ON);
    assign cycle_start     = cyc_end;

    wire [7:0] status_word = {3'h0, acc_ext, latch_full, act_tri,
                              act_mode};

    // Read mux for the setup phase
    wire [7:0] rd_byte =
        hit_mode ? {mode_reg, 4'h0} :
        hit_p2o  ? p2_out :
        hit_p2d  ? p2_dir :
        hit_p2i  ? p2_read :
        hit_p3o  ? p3_out :
        hit_p3d  ? p3_dir :
        hit_p3i  ? p3_sync :
        hit_p4o  ? p4_out :
        hit_p4d  ? p4_dir :
        hit_p4i  ? p4_sync :
        hit_st   ? status_word : 8'h00;

    // Read data registered in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= pbm_pkg::MODE_RST;
            // Directions reset to input; only third port pins 7:6 drive before set up, from full address mode
            p2_out   <= pbm_pkg::PORT_RST;
            p2_dir   <= pbm_pkg::PORT_RST;
            p3_out   <= pbm_pkg::PORT_RST;
            p3_dir   <= pbm_pkg::PORT_RST;
            p4_out   <= pbm_pkg::PORT_RST;
            p4_dir   <= pbm_pkg::PORT_RST;
        end else if (access_wr) begin
            if (hit_mode) mode_reg <= pwdata[7:4];
            if (hit_p2o)  p2_out   <= pwdata[7:0];
            if (hit_p2d)  p2_dir   <= pwdata[7:0];
            if (hit_p3o)  p3_out   <= pwdata[7:0];
            if (hit_p3d)  p3_dir   <= pwdata[7:0];
            if (hit_p4o)  p4_out   <= pwdata[7:0];
            if (hit_p4d)  p4_dir   <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Input latch on the second port
    // ----------------------------------------------------------------
    // The strobe comes from outside; only its synced rising edge counts
    wire strobe_rise = strobe_sync && !strobe_prev;
    wire lfull_clr   = access_wr && hit_st && pwdata[pbm_pkg::ST_LFULL_BIT];

    // Full flag: a capture in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_prev <= 1'b0;
            p2_latch    <= pbm_pkg::PORT_RST;
            latch_full  <= 1'b0;
        end else begin
            strobe_prev <= strobe_sync;
            if (latch_on && strobe_rise) begin
                p2_latch   <= p2_sync;
                latch_full <= 1'b1;
            end else if (lfull_clr) begin
                latch_full <= 1'b0;
            end
        end
    end

    // Phase-2 divider and per-cycle capture of access and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt   <= 4'h0;
            phi2_q    <= 1'b0;
            act_mode  <= pbm_pkg::MODE_RST[3:2];
            act_tri   <= 1'b0;
            acc_addr  <= pbm_pkg::ADDR_RST;
            acc_rw    <= 1'b1;
            acc_wdata <= pbm_pkg::PORT_RST;
            acc_ext   <= 1'b0;
        end else begin
            cyc_cnt <= next_cnt;
            phi2_q  <= next_phi2;
            if (cyc_end) begin
                // Mode is sampled only at a cycle boundary
                act_mode  <= mode_reg[3:2];
                act_tri   <= mode_reg[1];
                acc_addr  <= cpu_addr;
                acc_rw    <= cpu_rw;
                acc_wdata <= cpu_wdata;
                acc_ext   <= cpu_ext;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin function selection
    // ----------------------------------------------------------------
    wire is_full  = (act_mode == pbm_pkg::PBM_FULL_ADDR);
    wire is_abbr  = (act_mode == pbm_pkg::PBM_ABBREV);
    wire is_mux   = (act_mode == pbm_pkg::PBM_MUXED);
    // I/O bus mode leaves every pin to general I/O
    wire is_bus   = is_abbr | is_mux;

    // External memory select, low over the whole access cycle
    // Gated by an external access so internal cycles never select
    wire in_win   = (acc_addr >= pbm_pkg::WIN_LO) &&
                    (acc_addr <= pbm_pkg::WIN_HI);
    wire sel_n    = !(acc_ext && in_win);

    // Six address bits in abbreviated mode give 64 locations;
    // multiplexed adds A4-A11 for 14 bits, 16K
    wire [7:0] p3_bus = {sel_n, acc_addr[13], acc_rw, acc_addr[12],
                         acc_addr[3:0]};

    // General I/O on the second and third ports: only a low is driven, a high is the pull-up
    // Latch select overrides direction so no pin fights the strobe data
    wire [7:0] p2_drv  = latch_on ? 8'h00 : p2_dir;
    wire [7:0] p2_oe_n = ~(p2_drv & ~p2_out);
    wire [7:0] p3_oe_g = ~(p3_dir & ~p3_out);

    // Third port: bus pins driven at both levels
    // Bus and full modes ignore the direction bits of the owned pins
    wire [7:0] p3_o =
        is_bus  ? p3_bus :
        is_full ? {acc_addr[14], acc_addr[13], 6'h00} :
                  8'h00;
    wire [7:0] p3_e =
        is_bus  ? 8'h00 :
        is_full ? {2'h0, p3_oe_g[5:0]} :
                  p3_oe_g;

    // Fourth port; bus modes assume the driver select is set
    // Non-external writes leave the data bus floating in phase two
    wire wr_phase = acc_ext && !acc_rw && phi2_q;
    wire [7:0] p4_o =
        (is_mux && !phi2_q) ? acc_addr[11:4] :
        is_bus              ? acc_wdata :
        act_tri             ? p4_out : 8'h00;
    wire [7:0] p4_e =
        (is_mux && !phi2_q) ? 8'h00 :
        is_bus              ? {8{!wr_phase}} :
        act_tri             ? ~p4_dir :
                              ~(p4_dir & ~p4_out);

    // Read capture at the last clock of phase two
    wire rd_take = cyc_end && is_bus && acc_ext && acc_rw;

    // Pin registers, aligned with the registered phase-2 output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phi2             <= 1'b0;
            second_port_out  <= 8'h00;
            second_port_oe_n <= 8'hFF;
            third_port_out   <= 8'h00;
            third_port_oe_n  <= 8'hFF;
            fourth_port_out  <= 8'h00;
            fourth_port_oe_n <= 8'hFF;
        end else begin
            phi2             <= phi2_q;
            second_port_out  <= 8'h00;
            second_port_oe_n <= p2_oe_n;
            third_port_out   <= p3_o;
            third_port_oe_n  <= p3_e;
            fourth_port_out  <= p4_o;
            fourth_port_oe_n <= p4_e;
        end
    end

    // Bus read data returned to the processor side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_rdata       <= 8'h00;
            cpu_rdata_valid <= 1'b0;
        end else begin
            cpu_rdata_valid <= rd_take;
            if (rd_take) begin
                // Two-stage lag: the data stood on the pins two clocks ago
                cpu_rdata <= p4_sync;
            end
        end
    end

endmodule : pbm_port_bus_mux

`default_nettype wire

// File: pbm_pkg.sv
package pbm_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_OFS    = 8'h00;
    localparam logic [7:0] P2_OUT_OFS  = 8'h04;
    localparam logic [7:0] P2_DIR_OFS  = 8'h08;
    localparam logic [7:0] P2_IN_OFS   = 8'h0C;
    localparam logic [7:0] P3_OUT_OFS  = 8'h10;
    localparam logic [7:0] P3_DIR_OFS  = 8'h14;
    localparam logic [7:0] P3_IN_OFS   = 8'h18;
    localparam logic [7:0] P4_OUT_OFS  = 8'h1C;
    localparam logic [7:0] P4_DIR_OFS  = 8'h20;
    localparam logic [7:0] P4_IN_OFS   = 8'h24;
    localparam logic [7:0] STATUS_OFS  = 8'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int LATCH_SEL_BIT = 4;
    localparam int TRI_SEL_BIT   = 5;
    localparam int MODE_LO_BIT   = 6;
    localparam int MODE_HI_BIT   = 7;
    localparam int ST_MODE_LO    = 0;
    localparam int ST_MODE_HI    = 1;
    localparam int ST_TRI_BIT    = 2;
    localparam int ST_LFULL_BIT  = 3;
    localparam int ST_EXT_BIT    = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  MODE_RST = 4'h0;
    localparam logic [7:0]  PORT_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    // ----------------------------------------------------------------
    // External memory select window
    // ----------------------------------------------------------------
    localparam logic [15:0] WIN_LO = 16'h0100;
    localparam logic [15:0] WIN_HI = 16'h3FFF;

    // ----------------------------------------------------------------
    // Timing: processor cycle made from the 10 MHz clock
    // ----------------------------------------------------------------
    localparam int PCLK_NS      = 100;
    localparam int CPU_CYCLE_NS = 1000;
    localparam int CYCLE_CLKS   = CPU_CYCLE_NS / PCLK_NS;
    localparam logic [3:0] CYC_LAST = 4'(CYCLE_CLKS - 1);
    localparam logic [3:0] PHI2_ON  = 4'(CYCLE_CLKS / 2);

    // Bus modes, encoded as the two mode bits
    typedef enum logic [1:0] {
        PBM_FULL_ADDR = 2'h0,
        PBM_IO_BUS    = 2'h1,
        PBM_ABBREV    = 2'h2,
        PBM_MUXED     = 2'h3
    } pbm_mode_e;

endpackage : pbm_pkg

// File: pbm_sync.sv
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------
// Two flip-flop synchroniser for pin inputs
// --------------------------------------------------------------------
module pbm_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : pbm_sync

`default_nettype wire

// File: pbm_port_bus_mux_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Pin checks against a shadow of mode and processor access
// ----------------------------------------------------------------
module pbm_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_rw,
    input wire logic [7:0]  cpu_wdata,
    input wire logic        cpu_ext,
    input wire logic        cycle_start,
    input wire logic        phi2,
    input wire logic [7:0]  second_port_out,
    input wire logic [7:0]  second_port_oe_n,
    input wire logic [7:0]  third_port_out,
    input wire logic [7:0]  third_port_oe_n,
    input wire logic [7:0]  fourth_port_out,
    input wire logic [7:0]  fourth_port_oe_n
);
    logic [3:0]  msh;
    logic [27:0] cq, pq;
    logic        cs_d, pv;
    wire  [1:0]  pm = pq[27:26];
    wire         pr = pq[24];
    wire  [7:0]  pw = pq[23:16];
    wire  [15:0] pa = pq[15:0];
    wire         bus = pv && pm[1];
    wire         win = pq[25] && pa >= pbm_pkg::WIN_LO &&
                       pa <= pbm_pkg::WIN_HI;

    // Two stages: taken at cycle start, then seen on the pins a clock
    // later; pv hides the pins until the first cycle after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msh <= 4'h0;
            cq <= 28'h0000000;
            pq <= 28'h0000000;
            cs_d <= 1'b0;
            pv <= 1'b0;
        end else begin
            if (psel && penable && pwrite && paddr == pbm_pkg::MODE_OFS)
                msh <= pwdata[7:4];
            if (cycle_start)
                cq <= {msh[3:2], cpu_ext, cpu_rw, cpu_wdata, cpu_addr};
            if (cs_d)
                pq <= cq;
            pv <= pv | cs_d;
            cs_d <= cycle_start;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pb_low; (second_port_out & ~second_port_oe_n) == 8'h00;
    endproperty
    a_pb_low: assert property (p_pb_low)
        else $error("second port drives a one");
    property p_latch; msh[0] [*3] |-> second_port_oe_n == 8'hFF;
    endproperty
    a_latch: assert property (p_latch)
        else $error("second port driven while latching");
    property p_full; pv && pm == 2'h0 |-> third_port_oe_n[7:6] == 2'h0
        && third_port_out[7:6] == pa[14:13]; endproperty
    a_full: assert property (p_full)
        else $error("top address bits wrong");
    property p_io; pv && pm == 2'h1 |->
        (third_port_out & ~third_port_oe_n) == 8'h00; endproperty
    a_io: assert property (p_io)
        else $error("third port not general pins");
    property p_pc_bus; bus && phi2 |-> third_port_oe_n == 8'h00
        && third_port_out[6:0] == {pa[13], pr, pa[12], pa[3:0]}; endproperty
    a_pc_bus: assert property (p_pc_bus)
        else $error("third port bus pins wrong");
    property p_sel; bus && phi2 |-> third_port_out[7] == !win; endproperty
    a_sel: assert property (p_sel)
        else $error("memory select wrong");
    property p_pd_adr; bus && pm[0] && !phi2 |-> fourth_port_oe_n == 8'h00
        && fourth_port_out == pa[11:4]; endproperty
    a_pd_adr: assert property (p_pd_adr)
        else $error("fourth port address wrong");
    property p_pd_oe; bus && phi2 |-> fourth_port_oe_n == {8{pr || !pq[25]}};
    endproperty
    a_pd_oe: assert property (p_pd_oe)
        else $error("data drivers wrong in phase two");
    property p_pd_flt; bus && !pm[0] && !phi2 |-> fourth_port_oe_n == 8'hFF;
    endproperty
    a_pd_flt: assert property (p_pd_flt)
        else $error("data bus driven in phase one");
    property p_pd_dat; bus && phi2 && !pr |-> fourth_port_out == pw;
    endproperty
    a_pd_dat: assert property (p_pd_dat)
        else $error("write data wrong");
endmodule : pbm_chk

bind pbm_port_bus_mux pbm_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_addr(cpu_addr),
    .cpu_rw(cpu_rw), .cpu_wdata(cpu_wdata), .cpu_ext(cpu_ext),
    .cycle_start(cycle_start), .phi2(phi2),
    .second_port_out(second_port_out), .second_port_oe_n(second_port_oe_n),
    .third_port_out(third_port_out), .third_port_oe_n(third_port_oe_n),
    .fourth_port_out(fourth_port_out), .fourth_port_oe_n(fourth_port_oe_n)
);
`default_nettype wire

// File: pbm_ext_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// External memory and address holding register
// ----------------------------------------------------------------
module pbm_ext_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       phi2,
    input  wire logic [7:0] ctl,
    input  wire logic [7:0] ctl_oe_n,
    input  wire logic [7:0] dat_out,
    input  wire logic [7:0] dat_oe_n,
    output logic      [7:0] dat,
    output logic      [7:0] lat
);
    logic [7:0] last;
    // Answers only a selected read in phase two with all bus pins driven
    wire        rd  = phi2 && ctl_oe_n == 8'h00 && !ctl[7] && ctl[5];
    wire  [7:0] src = rd ? (8'hA0 | {4'h0, ctl[3:0]}) : ~last;

    // No pull-up here: released bits toggle so no stale value survives
    assign dat = (dat_out & ~dat_oe_n) | (src & dat_oe_n);

    // Holding register follows the bus while phase two is low and every data pin is driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 8'h00;
            lat <= 8'h00;
        end else begin
            last <= dat;
            if (!phi2 && dat_oe_n == 8'h00)
                lat <= dat;
        end
    end
endmodule : pbm_ext_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Bench for the port and bus mode block
// ----------------------------------------------------------------
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, rerr;
    logic        penable = 1'b0, pwrite = 1'b0, cpu_rw = 1'b1;
    logic        cpu_ext = 1'b0, strobe = 1'b0;
    logic [7:0]  paddr = 8'h00, cpu_wdata = 8'h00, p2_ext = 8'hFF;
    logic [7:0]  exp_rd = 8'h00;
    logic [15:0] cpu_addr = 16'h0000;
    logic [31:0] pwdata = 32'h0, rdat;
    int          bad_count = 0, compares = 0, n_exp = 0, n_valid = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, cycle_start, cpu_rdata_valid, phi2;
    wire  [7:0]  cpu_rdata, p2_out, p2_oe, p3_out, p3_oe, p4_out, p4_oe;
    wire  [7:0]  p2_w, p3_w, p4_w, lat;

    always #50 pclk = ~pclk;
    // Pull-ups on the second and third ports; outside drive on the second
    assign p2_w = p2_ext & (p2_out | p2_oe);
    assign p3_w = p3_out | p3_oe;

    pbm_port_bus_mux dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
        .cpu_rw(cpu_rw), .cpu_wdata(cpu_wdata), .cpu_ext(cpu_ext),
        .cycle_start(cycle_start), .cpu_rdata(cpu_rdata),
        .cpu_rdata_valid(cpu_rdata_valid), .phi2(phi2),
        .latch_strobe_pin(strobe), .second_port_in(p2_w),
        .second_port_out(p2_out), .second_port_oe_n(p2_oe),
        .third_port_in(p3_w), .third_port_out(p3_out),
        .third_port_oe_n(p3_oe), .fourth_port_in(p4_w),
        .fourth_port_out(p4_out), .fourth_port_oe_n(p4_oe));
    pbm_ext_model ext_u (.pclk(pclk), .presetn(presetn), .phi2(phi2),
        .ctl(p3_w), .ctl_oe_n(p3_oe), .dat_out(p4_out), .dat_oe_n(p4_oe),
        .dat(p4_w), .lat(lat));

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic timeout;
        bad_count++;
        end_of_test();
    endtask : timeout

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One register transfer; idles a cycle after so strobes never collide
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            timeout();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Present an access; returns at the edge that takes it
    task automatic cpu(input logic [15:0] a, input logic rw,
                       input logic [7:0] d, input logic x);
        int n;
        cpu_addr <= a;
        cpu_rw <= rw;
        cpu_wdata <= d;
        cpu_ext <= x;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (cycle_start !== 1'b1 && n < 24);
        if (n >= 24)
            timeout();
        @(posedge pclk);
    endtask : cpu

    // Read data is judged whenever the design flags it
    always @(negedge pclk) begin
        if (cpu_rdata_valid === 1'b1) begin
            n_valid++;
            chk("cpu_rdata", exp_rd, cpu_rdata);
        end
    end

    task automatic t_reset;
        @(negedge pclk);
        chk("third oe_n", 8'h3F, p3_oe);
        chk("fourth oe_n", 8'hFF, p4_oe);
        @(posedge pclk);
        apb(1'b0, pbm_pkg::MODE_OFS, 32'h0);
        chk("mode", 32'h0, rdat);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("slverr", 1'b1, rerr);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ports;
        p2_ext <= 8'h7F;
        apb(1'b1, pbm_pkg::MODE_OFS, 32'h60);
        apb(1'b1, pbm_pkg::P2_DIR_OFS, 32'h0F);
        apb(1'b1, pbm_pkg::P2_OUT_OFS, 32'h05);
        apb(1'b1, pbm_pkg::P4_DIR_OFS, 32'hFF);
        apb(1'b1, pbm_pkg::P4_OUT_OFS, 32'h3C);
        cpu(16'h0000, 1'b1, 8'h00, 1'b0);
        cpu(16'h0000, 1'b1, 8'h00, 1'b0);
        @(negedge pclk);
        chk("second oe_n", 8'hF5, p2_oe);
        chk("fourth oe_n", 8'h00, p4_oe);
        chk("fourth out", 8'h3C, p4_out);
        @(posedge pclk);
        apb(1'b0, pbm_pkg::P2_IN_OFS, 32'h0);
        chk("second in", 8'h75, rdat[7:0]);
        apb(1'b1, pbm_pkg::MODE_OFS, 32'h40);
        cpu(16'h0000, 1'b1, 8'h00, 1'b0);
        cpu(16'h0000, 1'b1, 8'h00, 1'b0);
        @(negedge pclk);
        chk("fourth oe_n", 8'h3C, p4_oe);
        @(posedge pclk);
        $display("test ports done");
    endtask : t_ports

    task automatic t_latch;
        p2_ext <= 8'hA5;
        apb(1'b1, pbm_pkg::MODE_OFS, 32'h10);
        repeat (4) @(posedge pclk);
        strobe <= 1'b1;
        repeat (4) @(posedge pclk);
        strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        p2_ext <= 8'h3C;
        repeat (4) @(negedge pclk);
        chk("second oe_n", 8'hFF, p2_oe);
        @(posedge pclk);
        apb(1'b0, pbm_pkg::P2_IN_OFS, 32'h0);
        chk("latched in", 8'hA5, rdat[7:0]);
        apb(1'b0, pbm_pkg::STATUS_OFS, 32'h0);
        chk("latch full", 1'b1, rdat[pbm_pkg::ST_LFULL_BIT]);
        apb(1'b1, pbm_pkg::MODE_OFS, 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, pbm_pkg::P2_IN_OFS, 32'h0);
        chk("second in", 8'h34, rdat[7:0]);
        $display("test latch done");
    endtask : t_latch

    // Every bus mode; select window edges, inside and outside accesses
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, pbm_pkg::MODE_OFS, {24'h0, 2'(m), 6'h20});
            cpu(16'h0100, 1'b0, 8'h5A, 1'b1);
            exp_rd = 8'hA7;
            n_exp += m / 2;
            cpu(16'h2A57, 1'b1, 8'h00, 1'b1);
            cpu(16'h3FFF, 1'b0, 8'hC3, 1'b1);
            cpu(16'h4000, 1'b0, 8'h3C, 1'b1);
            cpu(16'h00FF, 1'b0, 8'h96, 1'b1);
            cpu(16'h0234, 1'b0, 8'h69, 1'b0);
            apb(1'b0, pbm_pkg::STATUS_OFS, 32'h0);
            chk("active mode", 32'(m), {30'h0, rdat[1:0]});
            @(negedge pclk);
            if (m == 3)
                chk("held address", 8'h23, lat);
            @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
        chk("read pulses", 32'(n_exp), 32'(n_valid));
        $display("test modes done");
    endtask : t_modes

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ports();
        t_latch();
        t_modes();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
